// File: hdl/adc_decimation_paths_regs.vh
`ifndef ADC_DECIMATION_PATHS_REGS_VH
`define ADC_DECIMATION_PATHS_REGS_VH

// Register byte offsets
`define ADP_CTRL_OFS        12'h000
`define ADP_STATUS_OFS      12'h004
`define ADP_AUDIO1_OFS      12'h008
`define ADP_AUDIO2_OFS      12'h00c

// Control field positions and reset value
`define ADP_CTRL_VOICE_LSB  0
`define ADP_CTRL_DCREM_LSB  2
`define ADP_CTRL_RESET      4'h0

// Status field positions
`define ADP_STAT_OVR_LSB    0
`define ADP_STAT_FILL1_LSB  4
`define ADP_STAT_FILL2_LSB  6

// Decimation counts (last count value of each divider)
`define ADP_AUD_CIC_LAST    4'hf
`define ADP_AUX_CIC_LAST    6'h3f
`define ADP_LEVEL_TAP_LAST  4'hf
`define ADP_STG2_LAST       3'h7

// Arithmetic constants
`define ADP_REHASH_SHIFT    3
`define ADP_LEVEL_SHIFT     7
`define ADP_GAIN_Q14        32'sh00006fe3
`define ADP_GAIN_FRAC       14
`define ADP_DC_SHIFT        10
`define ADP_HP_SHIFT        1

`endif

// File: hdl/adc_decimation_paths.v
`timescale 1ns/1ps
`include "adc_decimation_paths_regs.vh"

module adc_decimation_paths (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Modulator bitstreams, one bit per unit, with a 128 fs strobe
    input  wire        mod_tick,
    input  wire [1:0]  aux_bits,
    input  wire [1:0]  audio_bits,
    // Audio samples at fs, through a two-entry buffer
    output wire [31:0] audio_data,
    output wire [1:0]  audio_valid,
    input  wire [1:0]  audio_ready,
    // Aux samples at fs
    output wire [31:0] aux_data,
    output wire [1:0]  aux_valid,
    // Level detection samples at 8 fs
    output wire [31:0] level_data,
    output wire [1:0]  level_valid
);

    // Saturate a wide signed value into 16 bits
    // Clipping instead of wrapping keeps a full-scale input from flipping sign
    function [15:0] sat16;
        input signed [31:0] v;
        begin
            if (v > 32'sd32767)
                sat16 = 16'h7fff;
            else if (v < -32'sd32768)
                sat16 = 16'h8000;
            else
                sat16 = v[15:0];
        end
    endfunction

    // Bitstream synchronisers; the strobe gets a third stage for edge detect
    // Bits and strobe share the same delay, so a bit is settled when its tick is seen
    reg  [1:0]  aux_s1_r;
    reg  [1:0]  aux_s2_r;
    reg  [1:0]  aud_s1_r;
    reg  [1:0]  aud_s2_r;
    reg         tick_s1_r;
    reg         tick_s2_r;
    reg         tick_s3_r;
    wire        tick = tick_s2_r & ~tick_s3_r;

    always @(posedge core_clk) begin
        aux_s1_r  <= aux_bits;
        aux_s2_r  <= aux_s1_r;
        aud_s1_r  <= audio_bits;
        aud_s2_r  <= aud_s1_r;
        tick_s1_r <= mod_tick;
        tick_s2_r <= tick_s1_r;
        tick_s3_r <= tick_s2_r;
    end

    // Shared rate dividers; both units run in lock step
    reg  [3:0]  aud_cnt_r;
    reg  [5:0]  aux_cnt_r;
    reg  [2:0]  stg2_cnt_r;
    reg         aux_phase_r;
    // One shared tick count: the 8 fs level tap and the 2 fs dump stay aligned,
    // and the audio count, stepped on the same tick, puts its push in the same cycle as the aux strobe
    wire        aud_dec  = tick && (aud_cnt_r == `ADP_AUD_CIC_LAST);
    wire        aux_dec  = tick && (aux_cnt_r == `ADP_AUX_CIC_LAST);
    wire        lev_dec  = tick && (aux_cnt_r[3:0] == `ADP_LEVEL_TAP_LAST);
    reg         cic_v_r;
    reg         stg2_v_r;
    reg         comp_v_r;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            aud_cnt_r   <= 4'h0;
            aux_cnt_r   <= 6'h00;
            stg2_cnt_r  <= 3'h0;
            aux_phase_r <= 1'b0;
            cic_v_r     <= 1'b0;
            stg2_v_r    <= 1'b0;
            comp_v_r    <= 1'b0;
        end else begin
            if (tick) begin
                aud_cnt_r <= aud_cnt_r + 4'h1;
                aux_cnt_r <= aux_cnt_r + 6'h01;
            end
            cic_v_r  <= aud_dec;
            // Second stage keeps one of eight rehashed samples
            // The count wraps by itself, so no compare against eight is needed
            stg2_v_r <= cic_v_r && (stg2_cnt_r == `ADP_STG2_LAST);
            if (cic_v_r)
                stg2_cnt_r <= stg2_cnt_r + 3'h1;
            comp_v_r <= aux_dec;
            if (comp_v_r)
                aux_phase_r <= ~aux_phase_r;
        end
    end

    // Control and status registers
    reg  [3:0]  ctrl_r;
    reg  [1:0]  ovr_r;
    wire [1:0]  ovr_set;
    wire [3:0]  fill_w;
    wire [31:0] last_audio;

    // Two identical units
    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            // Audio CIC3 integrators and combs
            reg  signed [15:0] ai1_r, ai2_r, ai3_r;
            reg  signed [15:0] ad1_r, ad2_r, ad3_r;
            reg  signed [15:0] cic_r;
            reg  signed [18:0] acc_r;
            reg  signed [15:0] avg_r;
            reg  signed [25:0] dc_r;
            reg         [15:0] f0_r, f1_r;
            reg         [1:0]  fcnt_r;
            reg                fval_r;
            reg         [15:0] last_r;
            // Aux CIC2 integrators, main and level combs
            reg  signed [17:0] bi1_r, bi2_r;
            reg  signed [17:0] bd1_r, bd2_r;
            reg  signed [17:0] ld1_r, ld2_r;
            reg  signed [15:0] lp_r;
            reg         [15:0] lev_r;
            reg                lev_v_r;
            reg  signed [15:0] x0_r, x1_r, x2_r;
            reg  signed [15:0] comp_r, comp_prev_r;
            reg         [15:0] aux_r;
            reg                aux_v_r;

            wire signed [15:0] a_in  = aud_s2_r[u] ? 16'sh0001 : 16'shffff;
            wire signed [17:0] b_in  = aux_s2_r[u] ? 18'sh00001 : 18'sh3ffff;
            wire signed [15:0] ac1   = ai3_r - ad1_r;
            wire signed [15:0] ac2   = ac1 - ad2_r;
            wire signed [15:0] ac3   = ac2 - ad3_r;
            wire signed [17:0] bc1   = bi2_r - bd1_r;
            wire signed [17:0] bc2   = bc1 - bd2_r;
            wire signed [17:0] lc1   = bi2_r - ld1_r;
            wire signed [17:0] lc2   = lc1 - ld2_r;
            // Rehash CIC words into full-scale Q15
            wire signed [15:0] reh   = sat16({{16{cic_r[15]}}, cic_r} <<< `ADP_REHASH_SHIFT);
            wire signed [18:0] acc_n = acc_r + {{3{reh[15]}}, reh};
            wire signed [31:0] gprod = {{16{avg_r[15]}}, avg_r} * `ADP_GAIN_Q14;
            wire signed [15:0] gain  = sat16(gprod >>> `ADP_GAIN_FRAC);
            wire signed [15:0] dcv   = dc_r[25:10];
            wire signed [15:0] dout  = ctrl_r[`ADP_CTRL_DCREM_LSB + u] ?
                                       sat16({{16{gain[15]}}, gain} - {{16{dcv[15]}}, dcv}) :
                                       gain;
            wire signed [15:0] lx    = sat16({{14{lc2[17]}}, lc2} <<< `ADP_LEVEL_SHIFT);
            wire signed [15:0] bx    = sat16({{14{bc2[17]}}, bc2} <<< `ADP_REHASH_SHIFT);
            wire signed [31:0] hp_y  = {{16{lx[15]}}, lx} - {{16{lp_r[15]}}, lp_r};
            // Droop fix: 9/8 of the middle tap less 1/16 of each outer tap
            // Casts keep the shifts arithmetic; a bare concatenation is unsigned
            wire signed [31:0] cmp   = $signed({{16{x1_r[15]}}, x1_r} * 32'sd18
                                       - {{16{x0_r[15]}}, x0_r}
                                       - {{16{x2_r[15]}}, x2_r}) >>> 4;
            // Level characteristic: mean of the two 2 fs samples
            wire signed [31:0] lvl   = $signed({{16{comp_r[15]}}, comp_r}
                                       + {{16{comp_prev_r[15]}}, comp_prev_r}) >>> 1;
            // DC tracker error in 32 bits; 26 bits would wrap at full scale
            wire signed [31:0] dc_err = $signed({{16{gain[15]}}, gain} <<< `ADP_DC_SHIFT)
                                        - $signed({{6{dc_r[25]}}, dc_r});
            wire signed [31:0] dc_stp = dc_err >>> `ADP_DC_SHIFT;
            wire               push  = stg2_v_r;
            wire               pop   = fval_r & audio_ready[u];

            // Filter datapath; reset zeroes it, no settling is hidden afterwards
            // Zeroing only keeps the state defined; the start-up transient still shows
            always @(posedge core_clk) begin
                if (!reset_n) begin
                    ai1_r <= 16'sh0000; ai2_r <= 16'sh0000; ai3_r <= 16'sh0000;
                    ad1_r <= 16'sh0000; ad2_r <= 16'sh0000; ad3_r <= 16'sh0000;
                    cic_r <= 16'sh0000; acc_r <= 19'sh00000; avg_r <= 16'sh0000;
                    dc_r  <= 26'sh0000000;
                    bi1_r <= 18'sh00000; bi2_r <= 18'sh00000;
                    bd1_r <= 18'sh00000; bd2_r <= 18'sh00000;
                    ld1_r <= 18'sh00000; ld2_r <= 18'sh00000;
                    lp_r  <= 16'sh0000; lev_r <= 16'h0000; lev_v_r <= 1'b0;
                    x0_r  <= 16'sh0000; x1_r <= 16'sh0000; x2_r <= 16'sh0000;
                    comp_r <= 16'sh0000; comp_prev_r <= 16'sh0000;
                    aux_r <= 16'h0000; aux_v_r <= 1'b0;
                end else begin
                    // Integrators run at 128 fs
                    if (tick) begin
                        ai1_r <= ai1_r + a_in;
                        ai2_r <= ai2_r + ai1_r;
                        ai3_r <= ai3_r + ai2_r;
                        bi1_r <= bi1_r + b_in;
                        bi2_r <= bi2_r + bi1_r;
                    end
                    if (aud_dec) begin
                        ad1_r <= ai3_r; ad2_r <= ac1; ad3_r <= ac2;
                        cic_r <= ac3;
                    end
                    // Boxcar of eight, restarted after each output
                    if (cic_v_r) begin
                        if (stg2_cnt_r == `ADP_STG2_LAST) begin
                            acc_r <= 19'sh00000;
                            avg_r <= acc_n[18:3];
                        end else begin
                            acc_r <= acc_n;
                        end
                    end
                    // Slow DC tracker; tracking continues while bypassed
                    if (push)
                        dc_r <= dc_r + dc_stp[25:0];
                    // Level branch at 8 fs with a one-pole high-pass
                    lev_v_r <= lev_dec;
                    if (lev_dec) begin
                        ld1_r <= bi2_r; ld2_r <= lc1;
                        lev_r <= sat16(hp_y);
                        // Low-pass moves half way toward the input each sample
                        lp_r  <= lp_r + sat16(hp_y >>> `ADP_HP_SHIFT);
                    end
                    if (aux_dec) begin
                        bd1_r <= bi2_r; bd2_r <= bc1;
                        x0_r  <= bx; x1_r <= x0_r; x2_r <= x1_r;
                    end
                    // Final stage halves 2 fs to fs
                    aux_v_r <= comp_v_r & aux_phase_r;
                    if (comp_v_r) begin
                        comp_prev_r <= comp_r;
                        comp_r      <= sat16(cmp);
                        if (aux_phase_r)
                            aux_r <= ctrl_r[`ADP_CTRL_VOICE_LSB + u] ?
                                     sat16(cmp) : sat16(lvl);
                    end
                end
            end

            // Two-entry output buffer; a full buffer drops and flags
            always @(posedge core_clk) begin
                if (!reset_n) begin
                    f0_r   <= 16'h0000;
                    f1_r   <= 16'h0000;
                    fcnt_r <= 2'h0;
                    fval_r <= 1'b0;
                    last_r <= 16'h0000;
                end else begin
                    if (push)
                        last_r <= dout;
                    // Push with pop keeps the count; a full buffer that is being
                    // drained still takes the new word, so only a real stall drops
                    if (push && pop) begin
                        if (fcnt_r == 2'h1)
                            f0_r <= dout;
                        else
                            f0_r <= f1_r;
                        if (fcnt_r == 2'h2)
                            f1_r <= dout;
                    end else if (push && fcnt_r != 2'h2) begin
                        if (fcnt_r == 2'h0)
                            f0_r <= dout;
                        else
                            f1_r <= dout;
                        fcnt_r <= fcnt_r + 2'h1;
                        fval_r <= 1'b1;
                    end else if (pop) begin
                        f0_r   <= f1_r;
                        fcnt_r <= fcnt_r - 2'h1;
                        fval_r <= (fcnt_r == 2'h2);
                    end
                end
            end

            assign ovr_set[u]           = push & (fcnt_r == 2'h2) & ~pop;
            assign fill_w[2*u +: 2]     = fcnt_r;
            assign last_audio[16*u +: 16] = last_r;
            assign audio_data[16*u +: 16] = f0_r;
            assign audio_valid[u]       = fval_r;
            assign aux_data[16*u +: 16] = aux_r;
            assign aux_valid[u]         = aux_v_r;
            assign level_data[16*u +: 16] = lev_r;
            assign level_valid[u]       = lev_v_r;
        end
    endgenerate

    // APB slave: one wait-free answer the cycle after setup
    // Read data is latched at setup so it stands through the access cycle
    wire        acc_ph = psel & penable & pready;
    wire        hit    = (paddr == `ADP_CTRL_OFS) || (paddr == `ADP_STATUS_OFS) ||
                         (paddr == `ADP_AUDIO1_OFS) || (paddr == `ADP_AUDIO2_OFS);
    reg  [31:0] rd_nxt;

    always @* begin
        case (paddr)
            `ADP_CTRL_OFS:   rd_nxt = {28'h0000000, ctrl_r};
            `ADP_STATUS_OFS: rd_nxt = {24'h000000, fill_w, 2'h0, ovr_r};
            `ADP_AUDIO1_OFS: rd_nxt = {16'h0000, last_audio[15:0]};
            `ADP_AUDIO2_OFS: rd_nxt = {16'h0000, last_audio[31:16]};
            default:         rd_nxt = 32'h00000000;
        endcase
    end

    // Register writes; overrun sets win over write-one-to-clear
    always @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_r  <= `ADP_CTRL_RESET;
            ovr_r   <= 2'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel & ~penable)
                prdata <= pwrite ? 32'h00000000 : rd_nxt;
            if (acc_ph && pwrite && paddr == `ADP_CTRL_OFS)
                ctrl_r <= pwdata[3:0];
            if (acc_ph && pwrite && paddr == `ADP_STATUS_OFS)
                ovr_r <= (ovr_r & ~pwdata[1:0]) | ovr_set;
            else
                ovr_r <= ovr_r | ovr_set;
        end
    end

endmodule // adc_decimation_paths

// File: dv/mod_stream_src.sv
`timescale 1ns/1ps
// Behavioural pair of modulators: one bit per unit on every 128 fs tick
module mod_stream_src (
    // Clock
    input  wire       core_clk,
    // Levels to emit, 1 means +1
    input  wire [1:0] aux_lvl,
    input  wire [1:0] audio_lvl,
    // Bitstreams toward the filters
    output reg        mod_tick,
    output reg  [1:0] aux_bits,
    output reg  [1:0] audio_bits
);
    reg [2:0] ph_r;

    // Start values, since the modulators have no reset of their own
    initial begin
        ph_r = 3'h0;
        mod_tick = 1'b0;
        aux_bits = 2'b00;
        audio_bits = 2'b00;
    end

    // Tick high 4, low 4: edges stay far enough apart for the synchronisers
    always @(posedge core_clk) begin
        ph_r <= ph_r + 3'h1;
        mod_tick <= ph_r[2];
        // Bits move a cycle ahead of the tick so they are settled when taken
        if (ph_r == 3'h3) begin
            aux_bits <= aux_lvl;
            audio_bits <= audio_lvl;
        end
    end
endmodule // mod_stream_src

// File: dv/adc_decimation_paths_props.sv
`timescale 1ns/1ps
// Port-level checks of the bus handshake and the sample strobes
module adc_decimation_paths_props (
    // Clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // Bus
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    // Streams
    input wire [31:0] audio_data,
    input wire [1:0]  audio_valid,
    input wire [1:0]  audio_ready,
    input wire [1:0]  aux_valid,
    input wire [1:0]  level_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_SLVERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    // Level strobes at 8 fs are at least nine cycles apart
    AST_LEVEL_SPACING: assert property (level_valid[0] |=> !level_valid[0] [*8])
        else $error("level strobe too close");
    AST_AUX_SPACING: assert property (aux_valid[0] |=> !aux_valid[0] [*8])
        else $error("aux strobe too close");
    AST_LEVEL_LOCKSTEP: assert property (level_valid[0] == level_valid[1])
        else $error("units out of step on level");
    AST_AUX_LOCKSTEP: assert property (aux_valid[0] == aux_valid[1])
        else $error("units out of step on aux");
    // A stalled receiver must see the same word next cycle
    AST_AUDIO_HOLD: assert property (audio_valid[0] && !audio_ready[0]
        |=> audio_valid[0] && $stable(audio_data[15:0]))
        else $error("audio word lost under stall");

    CV_LEVEL: cover property (level_valid[0]);
    CV_AUX: cover property (aux_valid[0]);
    CV_STALL: cover property (audio_valid == 2'b11 && audio_ready == 2'b00);
    CV_ERR: cover property (pslverr);
endmodule // adc_decimation_paths_props

bind adc_decimation_paths adc_decimation_paths_props u_props (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .audio_data(audio_data),
    .audio_valid(audio_valid), .audio_ready(audio_ready),
    .aux_valid(aux_valid), .level_valid(level_valid)
);

// File: dv/adc_decimation_paths_bench.sv
`timescale 1ns/1ps
`include "adc_decimation_paths_regs.vh"
module adc_decimation_paths_bench;
    reg         core_clk, reset_n, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [1:0]  audio_ready, aux_lvl, audio_lvl;
    reg         er, tick_q;
    wire [31:0] prdata, audio_data, aux_data, level_data;
    wire        pready, pslverr, mod_tick;
    wire [1:0]  aux_bits, audio_bits, audio_valid, aux_valid, level_valid;
    integer     num_errors, cmp_count, n_lvl, n_tick, n_pop, a, b, c, i;

    adc_decimation_paths u_adc_decimation_paths (.core_clk(core_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_tick(mod_tick),
        .aux_bits(aux_bits), .audio_bits(audio_bits), .audio_data(audio_data),
        .audio_valid(audio_valid), .audio_ready(audio_ready), .aux_data(aux_data),
        .aux_valid(aux_valid), .level_data(level_data), .level_valid(level_valid));
    mod_stream_src u_mod_stream_src (.core_clk(core_clk), .aux_lvl(aux_lvl),
        .audio_lvl(audio_lvl), .mod_tick(mod_tick), .aux_bits(aux_bits),
        .audio_bits(audio_bits));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Event counters; non-blocking so snapshots at an edge never race them
    always @(posedge core_clk) begin
        tick_q <= mod_tick;
        if (!reset_n) begin
            n_lvl <= 0;
            n_tick <= 0;
            n_pop <= 0;
        end else begin
            if (level_valid[0] === 1'b1) n_lvl <= n_lvl + 1;
            if (mod_tick === 1'b1 && tick_q === 1'b0) n_tick <= n_tick + 1;
            if (audio_valid[0] === 1'b1 && audio_ready[0] === 1'b1) n_pop <= n_pop + 1;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // One bus transfer; holds the request until ready is seen at an edge
    task apb(input wr, input [11:0] ad, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge core_clk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge core_clk);
            end
            if (n == 20) num_errors = num_errors + 1;
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Bounded wait for the next aux strobe
    task wait_aux;
        integer n;
        begin
            n = 0;
            @(posedge core_clk);
            while (aux_valid[0] !== 1'b1 && n < 3000) begin
                n = n + 1;
                @(posedge core_clk);
            end
            if (n == 3000) num_errors = num_errors + 1;
        end
    endtask

    task t_regs;
        begin
            apb(1'b0, `ADP_CTRL_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, `ADP_STATUS_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, `ADP_CTRL_OFS, 32'hffffffff);
            apb(1'b0, `ADP_CTRL_OFS, 32'h0);
            chk(rd, 32'hf);
            apb(1'b1, 12'h010, 32'h0);
            chk(er, 1'b1);
            apb(1'b0, 12'h010, 32'h0);
            chk(rd, 32'h0);
            chk(er, 1'b1);
            apb(1'b1, `ADP_CTRL_OFS, 32'h0);
            $display("t_regs done");
        end
    endtask

    // Counts between two aux strobes fix all decimation ratios
    task t_rates;
        begin
            wait_aux;
            a = n_lvl;
            b = n_tick;
            c = n_pop;
            wait_aux;
            chk(n_tick - b, 128);
            chk(n_lvl - a, 8);
            chk(n_pop - c, 1);
            $display("t_rates done");
        end
    endtask

    // Opposite signs on the two inputs must stay on their own paths
    task t_paths;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                apb(1'b1, `ADP_CTRL_OFS, i ? 32'h3 : 32'h0);
                aux_lvl <= 2'b11;
                audio_lvl <= 2'b00;
                repeat (5) wait_aux;
                chk({aux_data[31], aux_data[15]}, 2'b00);
                apb(1'b0, `ADP_AUDIO1_OFS, 32'h0);
                chk(rd, 32'h8000);
                aux_lvl <= 2'b00;
                audio_lvl <= 2'b11;
                repeat (5) wait_aux;
                chk({aux_data[31], aux_data[15]}, 2'b11);
                apb(1'b0, `ADP_AUDIO2_OFS, 32'h0);
                chk(rd, 32'h7fff);
            end
            $display("t_paths done");
        end
    endtask

    // Stalled receiver: buffer fills to two, overrun is flagged, then drains
    task t_buffer;
        begin
            audio_ready <= 2'b00;
            repeat (4) wait_aux;
            chk(audio_valid, 2'b11);
            apb(1'b0, `ADP_STATUS_OFS, 32'h0);
            chk(rd, 32'ha3);
            audio_ready <= 2'b11;
            repeat (4) @(posedge core_clk);
            chk(audio_valid, 2'b00);
            apb(1'b1, `ADP_STATUS_OFS, 32'h3);
            apb(1'b0, `ADP_STATUS_OFS, 32'h0);
            chk(rd, 32'h0);
            $display("t_buffer done");
        end
    endtask

    // DC removal on: a long negative input no longer sits at negative full scale
    task t_dc;
        begin
            audio_lvl <= 2'b00;
            apb(1'b1, `ADP_CTRL_OFS, 32'hc);
            repeat (16) wait_aux;
            apb(1'b0, `ADP_AUDIO1_OFS, 32'h0);
            chk({rd[31:15], (rd[15:0] != 16'h8000)}, 18'h00003);
            $display("t_dc done");
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Watchdog well past the roughly 45k cycles the tests need
    initial begin
        #(25 * 90000);
        num_errors = num_errors + 1;
        end_sim;
    end

    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        audio_ready = 2'b11;
        aux_lvl = 2'b00;
        audio_lvl = 2'b00;
        {num_errors, cmp_count} = 0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs;
        t_rates;
        t_paths;
        t_buffer;
        t_dc;
        end_sim;
    end
endmodule // adc_decimation_paths_bench
